// ==== core/osr_defs.vh ====
// register indices, field positions and preset values of the operation status tree
`ifndef OSR_DEFS_VH
`define OSR_DEFS_VH
`define OSR_W          16
`define OSR_AW         5
`define OSR_VALID_MASK 16'h7fff
`define OSR_ZERO       16'h0000
`define OSR_ONES       16'h7fff
// group indices (register index = group * 8 + kind)
`define OSR_G_OP       2'h0
`define OSR_G_CAL      2'h1
`define OSR_G_LLF      2'h2
`define OSR_G_SEN      2'h3
// register kinds within a group
`define OSR_K_COND     3'h0
`define OSR_K_EVENT    3'h1
`define OSR_K_ENABLE   3'h2
`define OSR_K_RISE     3'h3
`define OSR_K_FALL     3'h4
// condition bit positions
`define OSR_BIT_CAL_ACTIVE  1
`define OSR_BIT_LLF_BELOW   3
`define OSR_BIT_SEN_READ    1
`define OSR_BIT_OP_CAL      0
`define OSR_BIT_OP_TRIG     5
`define OSR_BIT_OP_SENS     10
`define OSR_BIT_OP_LLF      11
`define OSR_BIT_OP_ULF      12
`endif

// ==== core/osr_group.v ====
// one status group: condition, edge filters, sticky event, enable, summary
`timescale 1ns/1ps
`include "osr_defs.vh"
module osr_group (
  input  wire                 clk_sys_i,
  input  wire                 rst_n_i,
  input  wire [`OSR_W-1:0]    cond_i,
  input  wire                 preset_i,
  input  wire                 wr_enable_i,
  input  wire                 wr_rise_i,
  input  wire                 wr_fall_i,
  input  wire [`OSR_W-1:0]    wdata_i,
  input  wire                 rd_event_i,
  output reg  [`OSR_W-1:0]    cond_o,
  output reg  [`OSR_W-1:0]    event_o,
  output reg  [`OSR_W-1:0]    enable_o,
  output reg  [`OSR_W-1:0]    rise_o,
  output reg  [`OSR_W-1:0]    fall_o,
  output wire                 summary_o
);
  wire [`OSR_W-1:0] cond_m;
  wire [`OSR_W-1:0] rose;
  wire [`OSR_W-1:0] fell;
  wire [`OSR_W-1:0] hits;
  wire [`OSR_W-1:0] kept;

  assign cond_m = cond_i & `OSR_VALID_MASK;
  assign rose   = cond_m & ~cond_o & rise_o;
  assign fell   = ~cond_m & cond_o & fall_o;
  assign hits   = rose | fell;
  // a hit in the clearing cycle survives the read
  assign kept   = rd_event_i ? `OSR_ZERO : event_o;
  assign summary_o = |(event_o & enable_o);

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cond_o   <= `OSR_ZERO;
      event_o  <= `OSR_ZERO;
      enable_o <= `OSR_ZERO;
      rise_o   <= `OSR_ONES;
      fall_o   <= `OSR_ZERO;
    end else begin
      cond_o  <= cond_m;
      event_o <= (kept | hits) & `OSR_VALID_MASK;
      if (preset_i) begin
        enable_o <= `OSR_ZERO;
        rise_o   <= `OSR_ONES;
        fall_o   <= `OSR_ZERO;
      end else begin
        if (wr_enable_i)
          enable_o <= wdata_i & `OSR_VALID_MASK;
        if (wr_rise_i)
          rise_o <= wdata_i & `OSR_VALID_MASK;
        if (wr_fall_i)
          fall_o <= wdata_i & `OSR_VALID_MASK;
      end
    end
  end
endmodule // osr_group

// ==== core/osr_tree.v ====
// operation status register tree with calibration, lower limit, sense groups
`timescale 1ns/1ps
`include "osr_defs.vh"
module osr_tree (
  input  wire                 clk_sys_i,
  input  wire                 rst_n_i,
  input  wire                 calib_busy_i,
  input  wire                 below_low_limit_i,
  input  wire                 eeprom_reading_i,
  input  wire                 trigger_wait_i,
  input  wire                 sensor_change_i,
  input  wire                 upper_limit_summary_i,
  input  wire                 preset_i,
  input  wire                 wr_i,
  input  wire                 rd_i,
  input  wire [`OSR_AW-1:0]   addr_i,
  input  wire [`OSR_W-1:0]    wdata_i,
  output reg  [`OSR_W-1:0]    rdata_o,
  output reg                  rvalid_o,
  output reg                  status_bit7_o
);
  // external status levels come from other clock domains
  reg [5:0] sync_a;
  reg [5:0] sync_b;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {upper_limit_summary_i, sensor_change_i, trigger_wait_i,
                 eeprom_reading_i, below_low_limit_i, calib_busy_i};
      sync_b <= sync_a;
    end
  end

  wire cal_busy_s  = sync_b[0];
  wire below_s     = sync_b[1];
  wire eeprom_s    = sync_b[2];
  wire trig_s      = sync_b[3];
  wire sens_chg_s  = sync_b[4];
  wire ulf_s       = sync_b[5];

  function sel;
    input [`OSR_AW-1:0] a;
    input [1:0]         g;
    input [2:0]         k;
    begin
      sel = (a == {g, k});
    end
  endfunction

  function [`OSR_W-1:0] onehot;
    input integer pos;
    input         v;
    begin
      onehot = `OSR_ZERO;
      onehot[pos] = v;
    end
  endfunction

  wire [`OSR_W-1:0] cal_cond_in;
  wire [`OSR_W-1:0] llf_cond_in;
  wire [`OSR_W-1:0] sen_cond_in;
  wire [`OSR_W-1:0] op_cond_in;
  wire              cal_sum;
  wire              llf_sum;
  wire              sen_sum;
  wire              op_sum;

  assign cal_cond_in = onehot(`OSR_BIT_CAL_ACTIVE, cal_busy_s);
  assign llf_cond_in = onehot(`OSR_BIT_LLF_BELOW, below_s);
  assign sen_cond_in = onehot(`OSR_BIT_SEN_READ, eeprom_s);
  assign op_cond_in  = onehot(`OSR_BIT_OP_CAL, cal_sum)
                     | onehot(`OSR_BIT_OP_TRIG, trig_s)
                     | onehot(`OSR_BIT_OP_SENS,
                              sen_sum | sens_chg_s)
                     | onehot(`OSR_BIT_OP_LLF, llf_sum)
                     | onehot(`OSR_BIT_OP_ULF, ulf_s);

  // writes to condition and event indices decode to nothing
  wire rd_op  = rd_i & sel(addr_i, `OSR_G_OP,  `OSR_K_EVENT);
  wire rd_cal = rd_i & sel(addr_i, `OSR_G_CAL, `OSR_K_EVENT);
  wire rd_llf = rd_i & sel(addr_i, `OSR_G_LLF, `OSR_K_EVENT);
  wire rd_sen = rd_i & sel(addr_i, `OSR_G_SEN, `OSR_K_EVENT);

  wire [`OSR_W-1:0] op_c,  op_e,  op_en,  op_r,  op_f;
  wire [`OSR_W-1:0] cal_c, cal_e, cal_en, cal_r, cal_f;
  wire [`OSR_W-1:0] llf_c, llf_e, llf_en, llf_r, llf_f;
  wire [`OSR_W-1:0] sen_c, sen_e, sen_en, sen_r, sen_f;

  osr_group u_op (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .cond_i      (op_cond_in),
    .preset_i    (preset_i),
    .wr_enable_i (wr_i & sel(addr_i, `OSR_G_OP, `OSR_K_ENABLE)),
    .wr_rise_i   (wr_i & sel(addr_i, `OSR_G_OP, `OSR_K_RISE)),
    .wr_fall_i   (wr_i & sel(addr_i, `OSR_G_OP, `OSR_K_FALL)),
    .wdata_i     (wdata_i),
    .rd_event_i  (rd_op),
    .cond_o      (op_c),
    .event_o     (op_e),
    .enable_o    (op_en),
    .rise_o      (op_r),
    .fall_o      (op_f),
    .summary_o   (op_sum)
  );

  osr_group u_cal (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .cond_i      (cal_cond_in),
    .preset_i    (preset_i),
    .wr_enable_i (wr_i & sel(addr_i, `OSR_G_CAL, `OSR_K_ENABLE)),
    .wr_rise_i   (wr_i & sel(addr_i, `OSR_G_CAL, `OSR_K_RISE)),
    .wr_fall_i   (wr_i & sel(addr_i, `OSR_G_CAL, `OSR_K_FALL)),
    .wdata_i     (wdata_i),
    .rd_event_i  (rd_cal),
    .cond_o      (cal_c),
    .event_o     (cal_e),
    .enable_o    (cal_en),
    .rise_o      (cal_r),
    .fall_o      (cal_f),
    .summary_o   (cal_sum)
  );

  osr_group u_llf (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .cond_i      (llf_cond_in),
    .preset_i    (preset_i),
    .wr_enable_i (wr_i & sel(addr_i, `OSR_G_LLF, `OSR_K_ENABLE)),
    .wr_rise_i   (wr_i & sel(addr_i, `OSR_G_LLF, `OSR_K_RISE)),
    .wr_fall_i   (wr_i & sel(addr_i, `OSR_G_LLF, `OSR_K_FALL)),
    .wdata_i     (wdata_i),
    .rd_event_i  (rd_llf),
    .cond_o      (llf_c),
    .event_o     (llf_e),
    .enable_o    (llf_en),
    .rise_o      (llf_r),
    .fall_o      (llf_f),
    .summary_o   (llf_sum)
  );

  osr_group u_sen (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .cond_i      (sen_cond_in),
    .preset_i    (preset_i),
    .wr_enable_i (wr_i & sel(addr_i, `OSR_G_SEN, `OSR_K_ENABLE)),
    .wr_rise_i   (wr_i & sel(addr_i, `OSR_G_SEN, `OSR_K_RISE)),
    .wr_fall_i   (wr_i & sel(addr_i, `OSR_G_SEN, `OSR_K_FALL)),
    .wdata_i     (wdata_i),
    .rd_event_i  (rd_sen),
    .cond_o      (sen_c),
    .event_o     (sen_e),
    .enable_o    (sen_en),
    .rise_o      (sen_r),
    .fall_o      (sen_f),
    .summary_o   (sen_sum)
  );

  // read mux; unmapped indices answer zero
  reg [`OSR_W-1:0] next_rdata;
  always @* begin
    next_rdata = `OSR_ZERO;
    if (sel(addr_i, `OSR_G_OP, `OSR_K_COND)) next_rdata = op_c;
    else if (sel(addr_i, `OSR_G_OP, `OSR_K_EVENT)) next_rdata = op_e;
    else if (sel(addr_i, `OSR_G_OP, `OSR_K_ENABLE)) next_rdata = op_en;
    else if (sel(addr_i, `OSR_G_OP, `OSR_K_RISE)) next_rdata = op_r;
    else if (sel(addr_i, `OSR_G_OP, `OSR_K_FALL)) next_rdata = op_f;
    else if (sel(addr_i, `OSR_G_CAL, `OSR_K_COND)) next_rdata = cal_c;
    else if (sel(addr_i, `OSR_G_CAL, `OSR_K_EVENT)) next_rdata = cal_e;
    else if (sel(addr_i, `OSR_G_CAL, `OSR_K_ENABLE)) next_rdata = cal_en;
    else if (sel(addr_i, `OSR_G_CAL, `OSR_K_RISE)) next_rdata = cal_r;
    else if (sel(addr_i, `OSR_G_CAL, `OSR_K_FALL)) next_rdata = cal_f;
    else if (sel(addr_i, `OSR_G_LLF, `OSR_K_COND)) next_rdata = llf_c;
    else if (sel(addr_i, `OSR_G_LLF, `OSR_K_EVENT)) next_rdata = llf_e;
    else if (sel(addr_i, `OSR_G_LLF, `OSR_K_ENABLE)) next_rdata = llf_en;
    else if (sel(addr_i, `OSR_G_LLF, `OSR_K_RISE)) next_rdata = llf_r;
    else if (sel(addr_i, `OSR_G_LLF, `OSR_K_FALL)) next_rdata = llf_f;
    else if (sel(addr_i, `OSR_G_SEN, `OSR_K_COND)) next_rdata = sen_c;
    else if (sel(addr_i, `OSR_G_SEN, `OSR_K_EVENT)) next_rdata = sen_e;
    else if (sel(addr_i, `OSR_G_SEN, `OSR_K_ENABLE)) next_rdata = sen_en;
    else if (sel(addr_i, `OSR_G_SEN, `OSR_K_RISE)) next_rdata = sen_r;
    else if (sel(addr_i, `OSR_G_SEN, `OSR_K_FALL)) next_rdata = sen_f;
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o       <= `OSR_ZERO;
      rvalid_o      <= 1'b0;
      status_bit7_o <= 1'b0;
    end else begin
      rvalid_o      <= rd_i;
      rdata_o       <= rd_i ? (next_rdata & `OSR_VALID_MASK) : `OSR_ZERO;
      status_bit7_o <= op_sum;
    end
  end
endmodule // osr_tree

// ==== verification/osr_props.sv ====
// port assertions for the operation status tree
`timescale 1ns/1ps
module osr_props (
  input wire        clk_sys_i,
  input wire        rst_n_i,
  input wire        calib_busy_i,
  input wire        preset_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [4:0]  addr_i,
  input wire [15:0] wdata_i,
  input wire [15:0] rdata_o,
  input wire        rvalid_o,
  input wire        status_bit7_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_rvalid_after_rd: assert property (rd_i |=> rvalid_o)
    else $error("read not answered");
  a_rvalid_only_rd: assert property (!rd_i |=> !rvalid_o)
    else $error("answer without read");
  a_rdata_idle_zero: assert property (!rvalid_o |-> rdata_o == 16'h0000)
    else $error("read data not zero when idle");
  a_top_bit_zero: assert property (rvalid_o |-> !rdata_o[15])
    else $error("bit 15 read as one");
  a_cal_cond_busy: assert property (rd_i && addr_i == 5'h08 &&
    $past(calib_busy_i, 3) |=> rdata_o == 16'h0002)
    else $error("calibration condition not 2");
  a_preset_bit7: assert property (preset_i |=> ##1 !status_bit7_o)
    else $error("status bit 7 after preset");
  a_preset_rise_ones: assert property (preset_i ##1 !wr_i ##1
    (rd_i && addr_i[2:0] == 3'h3) |=> rdata_o == 16'h7fff)
    else $error("rise filter not all ones after preset");
  a_wr_keeps_15bits: assert property (wr_i && !preset_i &&
    addr_i == 5'h0a ##1 (!wr_i && !preset_i) ##1 (rd_i && addr_i == 5'h0a)
    |=> rdata_o == ($past(wdata_i, 3) & 16'h7fff))
    else $error("enable readback not masked write");
endmodule // osr_props
bind osr_tree osr_props u_props (.clk_sys_i, .rst_n_i, .calib_busy_i,
  .preset_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o,
  .status_bit7_o);

// ==== verification/osr_host.sv ====
// host model issuing register writes and reads
`timescale 1ns/1ps
module osr_host (
  input  wire        clk_sys_i,
  input  wire [15:0] rdata_i,
  output reg         wr_o,
  output reg         rd_o,
  output reg  [4:0]  addr_o,
  output reg  [15:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 16'h0000;
  end
  // released lines are inverted so stale values cannot pass as live ones
  task wr(input [4:0] a, input [15:0] d);
    @(posedge clk_sys_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d; // bit 15 is set only as a refusal case
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task rd(input [4:0] a, output [15:0] d);
    @(posedge clk_sys_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_sys_i);
    d = rdata_i;
  endtask
endmodule // osr_host

// ==== verification/tb_top.sv ====
// self-checking bench for the operation status tree
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [4:0] a; logic [15:0] w; logic [15:0] e;} osr_row_t;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        calib_i = 1'b0;
  logic        below_i = 1'b0;
  logic        eeprom_i = 1'b0;
  logic        trig_i = 1'b0;
  logic        sens_i = 1'b0;
  logic        upper_i = 1'b0;
  logic        preset_i = 1'b0;
  wire         wr, rd, rvalid, bit7;
  wire  [4:0]  addr;
  wire  [15:0] wdata, rdata;
  logic [15:0] d;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;
  osr_row_t    rows [9] = '{'{5'h0a, 16'hffff, 16'h7fff},
    '{5'h0b, 16'h0006, 16'h0006}, '{5'h0c, 16'h8001, 16'h0001},
    '{5'h02, 16'h1234, 16'h1234}, '{5'h13, 16'h0008, 16'h0008},
    '{5'h1c, 16'h0002, 16'h0002}, '{5'h08, 16'hffff, 16'h0000},
    '{5'h09, 16'hffff, 16'h0000}, '{5'h05, 16'h1111, 16'h0000}};
  osr_tree u_dut (.clk_sys_i, .rst_n_i, .calib_busy_i(calib_i),
    .below_low_limit_i(below_i), .eeprom_reading_i(eeprom_i),
    .trigger_wait_i(trig_i), .sensor_change_i(sens_i),
    .upper_limit_summary_i(upper_i), .preset_i, .wr_i(wr), .rd_i(rd),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
    .status_bit7_o(bit7));
  osr_host u_host (.clk_sys_i, .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task rdc(input [4:0] a, input [15:0] e);
    u_host.rd(a, d);
    chk(d, e);
    chk({15'h0000, rvalid}, 16'h0001);
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ceiling is about eighteen times the roughly 160 cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdc(5'h0b, 16'h7fff);
    $display("reset values done");
    foreach (rows[i]) begin
      u_host.wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e);
    end
    $display("table done");
    @(posedge clk_sys_i);
    preset_i <= 1'b1;
    @(posedge clk_sys_i);
    preset_i <= 1'b0;
    rdc(5'h13, 16'h7fff);
    rdc(5'h0c, 16'h0000);
    rdc(5'h02, 16'h0000);
    $display("preset done");
    u_host.wr(5'h0a, 16'h0002);
    u_host.wr(5'h02, 16'h0001);
    @(posedge clk_sys_i);
    calib_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rdc(5'h08, 16'h0002);
    rdc(5'h00, 16'h0001);
    chk({15'h0000, bit7}, 16'h0001);
    rdc(5'h09, 16'h0002);
    rdc(5'h09, 16'h0000);
    rdc(5'h01, 16'h0001);
    repeat (4) @(posedge clk_sys_i);
    chk({15'h0000, bit7}, 16'h0000);
    u_host.wr(5'h0c, 16'h0002);
    @(posedge clk_sys_i);
    calib_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rdc(5'h09, 16'h0002);
    $display("calibration group done");
    u_host.wr(5'h12, 16'h0008);
    u_host.wr(5'h1a, 16'h0002);
    @(posedge clk_sys_i);
    below_i <= 1'b1;
    eeprom_i <= 1'b1;
    trig_i <= 1'b1;
    upper_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rdc(5'h10, 16'h0008);
    rdc(5'h18, 16'h0002);
    rdc(5'h00, 16'h1c20);
    rdc(5'h19, 16'h0002);
    repeat (4) @(posedge clk_sys_i);
    rdc(5'h00, 16'h1820);
    sens_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rdc(5'h00, 16'h1c20);
    $display("summary groups done");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk({15'h0000, bit7}, 16'h0000);
    rst_n_i <= 1'b1;
    rdc(5'h0a, 16'h0000);
    rdc(5'h13, 16'h7fff);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule // tb_top
